/* File: logic/bl_pkg.sv */
// shared constants and types
`default_nettype none
package bl_pkg;
  localparam int CLK_NS = 40;
  localparam int CLK_HZ = 25_000_000;
  localparam int SCL_PERIOD_NS = 320;
  localparam int Q_CYC = SCL_PERIOD_NS / (4 * CLK_NS);
  localparam int SW_FREQ_HZ = 1_000_000;
  localparam int SW_CYC = CLK_HZ / SW_FREQ_HZ;
  localparam int RESTART_US = 1000;
  localparam int RESTART_CYC = RESTART_US * (CLK_HZ / 1_000_000);
  localparam logic [6:0] DEF_SLAVE_ADDR = 7'h2C;
  // device register indices
  localparam logic [7:0] REG_BRT = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h01;
  localparam logic [7:0] REG_STAT = 8'h02;
  localparam logic [7:0] REG_ID = 8'h03;
  localparam logic [7:0] REG_COUNT = 8'h04;
  localparam logic [7:0] BRT_RST = 8'hFF;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam int MODE_ON_BIT = 0;
  localparam int MODE_SRC_BIT = 1;
  localparam int MODE_COMB_BIT = 2;
  localparam int ID_PANEL_BIT = 7;
  // host register map
  localparam logic [3:0] HR_CTRL = 4'h0;
  localparam logic [3:0] HR_STAT = 4'h4;
  localparam int CTRL_GO = 0;
  localparam int CTRL_RD = 1;
  localparam int CTRL_IDX_LSB = 8;
  localparam int CTRL_DAT_LSB = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam int STAT_DAT_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_RX = 5'b00010, S_ACK = 5'b00100, S_TX = 5'b01000, S_MACK = 5'b10000
  } bl_sstate_type;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001, H_START = 4'b0010, H_BIT = 4'b0100, H_STOP = 4'b1000
  } bl_hstate_type;
endpackage
`default_nettype wire

/* File: logic/bl_smbus_if.sv */
// SMBus link, open-drain data resolved here
`default_nettype none
interface bl_smbus_if;
  logic scl;
  logic sda;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport host(output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev(input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface
`default_nettype wire

/* File: logic/bl_dev.sv */
// backlight control: dimming, protection, SMBus slave
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
// Operation
// RULE1: PWM mode: sinks follow pwm pin
// RULE2: source keeps minimum duty; the code enforces no minimum duty
// RULE3: analog: sinks on, level from brightness
// RULE4: over clamp stops boost switch
// RULE5: open string at over-voltage disabled
// RULE6: sink pin over-voltage disables sink
// RULE7: disabled string stays off until reactivated
// RULE8: all strings open: auto restart
// RULE9: current limit ends switch cycle
// RULE10: sustained over-current latches off
// RULE11: short circuit latches off
// RULE12: over-temperature: off, auto restart
// RULE13: SMBus only when selected
// RULE14: four registers
// RULE15: address: seven bits plus direction
// RULE16: read: address, index, address, data
// RULE17: read returns indexed register
// RULE18: device drives only ack and read data
// RULE19: write: address, index, data
// RULE20: brightness from duty or SMBus
// RULE21: brightness resets to all ones
// RULE22: mode: bit0 on, bits1-2 mode
// RULE23: status: bit0 fault, bit3 on
// RULE24: index above four refused
module bl_dev
  import bl_pkg::*;
#(
  parameter int STRINGS = 8,
  parameter logic [6:0] SLAVE_ADDR = DEF_SLAVE_ADDR,
  parameter logic [3:0] MFG_ID = 4'h5, // arbitrary value
  parameter logic [2:0] REV_ID = 3'h1, // arbitrary value
  parameter int RESTART_CYCLES = RESTART_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // SMBus link
  bl_smbus_if.dev bus,
  // control pins
  input wire logic enable_pin,
  input wire logic interface_select_pin,
  input wire logic analog_select_pin,
  input wire logic pwm_pin,
  // sense inputs
  input wire logic [STRINGS-1:0] sink_zero_current,
  input wire logic [STRINGS-1:0] string_sink_pin_ov,
  input wire logic out_ov_threshold,
  input wire logic out_over_clamp,
  input wire logic out_below_clamp,
  input wire logic inductor_limit,
  input wire logic ocp_sustained,
  input wire logic out_short,
  input wire logic over_temp,
  // drive outputs
  output logic [STRINGS-1:0] sink_on,
  output logic [7:0] sink_level,
  output logic boost_switch_on,
  output logic backlight_state_flag
);
  localparam int NA = 2 * STRINGS + 13;
  logic [NA-1:0] meta;
  logic [NA-1:0] syn;
  logic pwm_s, sel_s, en_s, ana_s, ovt_s, ovc_s, blc_s, ilim_s, ocp_s, shrt_s, hot_s, scl_s, sda_s;
  logic [STRINGS-1:0] zero_s;
  logic [STRINGS-1:0] sov_s;
  logic lrst;
  logic scl_d, sda_d, pwm_d;
  logic [7:0] brightness_level_bits;
  logic [2:0] mode;
  logic [7:0] meas;
  logic meas_v;
  logic [19:0] per_cnt;
  logic [19:0] hi_cnt;
  logic [STRINGS-1:0] dis;
  logic [31:0] rs_cnt;
  logic ovh, ilat, ocp_lat, short_lat;
  logic [7:0] sw_cnt;
  logic sw_tick;
  bl_sstate_type st;
  logic [7:0] shreg;
  logic [3:0] bitn;
  logic [1:0] byten;
  logic rd_mode;
  logic [1:0] idx;
  logic wr_en;
  logic [7:0] wdat;
  logic mode_wr;
  logic fault;
  logic [1:0] cnt2;
  logic run;
  logic bl_on;
  logic [7:0] lvl;
  logic [15:0] prod;
  logic [7:0] rd_byte;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta <= '0;
      syn <= '0;
    end else begin
      meta <= {pwm_pin, interface_select_pin, enable_pin, analog_select_pin, out_ov_threshold,
               out_over_clamp, out_below_clamp, inductor_limit, ocp_sustained, out_short,
               over_temp, bus.scl, bus.sda, sink_zero_current, string_sink_pin_ov};
      syn <= meta;
    end
  end
  assign {pwm_s, sel_s, en_s, ana_s, ovt_s, ovc_s, blc_s, ilim_s, ocp_s, shrt_s, hot_s, scl_s,
          sda_s, zero_s, sov_s} = syn;
  // enable low resets the device
  assign lrst = rst | ~en_s;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      pwm_d <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      pwm_d <= pwm_s;
    end
  end

  // pwm duty, one result per period
  always_ff @(posedge clk_sys) begin
    if (lrst) begin
      per_cnt <= '0;
      hi_cnt <= '0;
      meas <= BRT_RST;
      meas_v <= 1'b0;
    end else begin
      meas_v <= 1'b0;
      if (pwm_s && !pwm_d) begin
        if (per_cnt != '0) begin
          meas <= 8'((28'(hi_cnt) * 28'd255) / 28'(per_cnt)); // [RULE20]
          meas_v <= 1'b1;
        end
        per_cnt <= 20'd1;
        hi_cnt <= 20'd1;
      end else if (per_cnt != '1) begin
        per_cnt <= per_cnt + 20'd1;
        hi_cnt <= hi_cnt + 20'(pwm_s);
      end
    end
  end

  // registers
  always_ff @(posedge clk_sys) begin
    if (lrst) begin
      brightness_level_bits <= BRT_RST; // [RULE21]
      mode <= MODE_RST;
    end else begin
      if (!sel_s && meas_v) begin
        brightness_level_bits <= meas; // [RULE20]
      end else if (wr_en && idx == REG_BRT[1:0]) begin
        brightness_level_bits <= wdat; // [RULE19] [RULE20]
      end
      if (wr_en && idx == REG_MODE[1:0]) begin
        mode <= wdat[2:0]; // [RULE22]
      end
    end
  end
  assign mode_wr = wr_en && idx == REG_MODE[1:0];

  assign fault = ocp_lat | hot_s | short_lat; // [RULE23]
  assign cnt2 = {$countones(dis) > 1, |dis};

  function automatic logic [7:0] rd_sel(input logic [1:0] i);
    unique case (i)
      REG_BRT[1:0]: rd_sel = brightness_level_bits;
      REG_MODE[1:0]: rd_sel = {5'h00, mode}; // [RULE22]
      REG_STAT[1:0]: rd_sel = {2'b00, cnt2, backlight_state_flag, ocp_lat, hot_s, fault}; // [RULE23]
      default: rd_sel = {1'b1, MFG_ID, REV_ID}; // [RULE14]
    endcase
  endfunction
  assign rd_byte = rd_sel(idx);

  // SMBus slave
  always_ff @(posedge clk_sys) begin
    if (lrst || !sel_s) begin // [RULE13]
      st <= S_IDLE;
      shreg <= '0;
      bitn <= '0;
      byten <= '0;
      rd_mode <= 1'b0;
      idx <= '0;
      wr_en <= 1'b0;
      wdat <= '0;
      bus.dev_sda_oe <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      if (scl_s && scl_d && sda_d && !sda_s) begin
        st <= S_RX;
        bitn <= '0;
        byten <= '0;
        rd_mode <= 1'b0;
        bus.dev_sda_oe <= 1'b0;
      end else if (scl_s && scl_d && !sda_d && sda_s) begin
        st <= S_IDLE;
        bus.dev_sda_oe <= 1'b0;
      end else begin
        unique case (st)
          S_IDLE: begin
            bus.dev_sda_oe <= 1'b0;
          end
          S_RX: begin
            if (scl_s && !scl_d) begin
              shreg <= {shreg[6:0], sda_s};
              bitn <= bitn + 4'd1;
            end else if (!scl_s && scl_d && bitn == 4'd8) begin
              bitn <= '0;
              st <= S_IDLE;
              if (byten == 2'd0 && shreg[7:1] == SLAVE_ADDR) begin // [RULE15]
                rd_mode <= shreg[0];
                st <= S_ACK;
                bus.dev_sda_oe <= 1'b1; // [RULE18]
              end else if (byten == 2'd1 && shreg < REG_COUNT) begin // [RULE24]
                idx <= shreg[1:0];
                st <= S_ACK;
                bus.dev_sda_oe <= 1'b1;
              end else if (byten == 2'd2) begin
                wr_en <= 1'b1; // [RULE19]
                wdat <= shreg;
                st <= S_ACK;
                bus.dev_sda_oe <= 1'b1;
              end
            end
          end
          S_ACK: begin
            if (!scl_s && scl_d) begin
              byten <= byten + 2'd1;
              bitn <= '0;
              if (rd_mode) begin
                st <= S_TX;
                shreg <= rd_byte; // [RULE17]
                bus.dev_sda_oe <= ~rd_byte[7]; // [RULE18]
              end else begin
                st <= S_RX;
                bus.dev_sda_oe <= 1'b0;
              end
            end
          end
          S_TX: begin
            if (!scl_s && scl_d) begin
              shreg <= {shreg[6:0], 1'b0};
              bitn <= bitn + 4'd1;
              if (bitn == 4'd7) begin
                st <= S_MACK;
                bus.dev_sda_oe <= 1'b0;
              end else begin
                bus.dev_sda_oe <= ~shreg[6];
              end
            end
          end
          S_MACK: begin
            bus.dev_sda_oe <= 1'b0;
            if (!scl_s && scl_d) begin
              st <= S_IDLE;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    bus.dev_sda_o <= 1'b0;
  end

  // switching cycle tick
  always_ff @(posedge clk_sys) begin
    if (lrst || sw_cnt == 8'(SW_CYC - 1)) begin
      sw_cnt <= '0;
    end else begin
      sw_cnt <= sw_cnt + 8'd1;
    end
  end
  assign sw_tick = sw_cnt == 8'(SW_CYC - 1);

  // protection latches; a set in the clearing cycle wins
  always_ff @(posedge clk_sys) begin
    if (lrst) begin
      ovh <= 1'b0;
      ilat <= 1'b0;
      ocp_lat <= 1'b0;
      short_lat <= 1'b0;
    end else begin
      ovh <= ovc_s | (ovh & ~blc_s); // [RULE4]
      ilat <= ilim_s | (ilat & ~sw_tick); // [RULE9]
      ocp_lat <= ocp_lat | ocp_s; // [RULE10]
      short_lat <= shrt_s | (short_lat & ~mode_wr); // [RULE11]
    end
  end

  for (genvar i = 0; i < STRINGS; i++) begin : g_str
    always_ff @(posedge clk_sys) begin
      if (lrst) begin
        dis[i] <= 1'b0;
      end else begin
        dis[i] <= (ovt_s & zero_s[i]) | sov_s[i] // [RULE5] [RULE6]
                  | (dis[i] & ~mode_wr & ~(rs_cnt == 32'(RESTART_CYCLES))); // [RULE7]
      end
    end
  end

  // all open: retry after a wait
  always_ff @(posedge clk_sys) begin
    if (lrst || !(&dis) || rs_cnt == 32'(RESTART_CYCLES)) begin
      rs_cnt <= '0;
    end else begin
      rs_cnt <= rs_cnt + 32'd1; // [RULE8]
    end
  end

  assign run = ~ocp_lat & ~short_lat & ~hot_s & ~(&dis); // [RULE12]
  assign bl_on = run & (~sel_s | mode[MODE_ON_BIT]);
  assign prod = brightness_level_bits * meas;
  always_comb begin
    if (!sel_s || (mode[MODE_COMB_BIT] && !mode[MODE_SRC_BIT])) begin
      lvl = brightness_level_bits;
    end else if (mode[MODE_SRC_BIT]) begin
      lvl = meas;
    end else begin
      lvl = prod[15:8];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (lrst) begin
      sink_on <= '0;
      sink_level <= '0;
      boost_switch_on <= 1'b0;
      backlight_state_flag <= 1'b0;
    end else begin
      sink_on <= {STRINGS{bl_on & (ana_s | pwm_s)}} & ~dis; // [RULE1] [RULE3]
      sink_level <= ana_s ? lvl : 8'hFF; // [RULE3]
      boost_switch_on <= bl_on & ~ovh & ~ilat & ~ilim_s; // [RULE4] [RULE9]
      backlight_state_flag <= bl_on; // [RULE23]
    end
  end
endmodule
`default_nettype wire

/* File: logic/bl_host.sv */
// SMBus host ordered over AXI4-Lite
`default_nettype none
module bl_host
  import bl_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = DEF_SLAVE_ADDR
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // SMBus link
  bl_smbus_if.host bus,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have, w_have;
  logic go, cmd_rd, busy, nack;
  logic [7:0] cmd_idx, cmd_dat, rx, rdat;
  logic sda_m, sda_s;
  bl_hstate_type st;
  logic [1:0] q;
  logic [7:0] qcnt;
  logic qtick;
  logic [3:0] bitn;
  logic [1:0] bsel;
  logic send, sda_pull;
  logic [7:0] txb;

  // write channel; commands while busy are dropped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      go <= 1'b0;
      cmd_rd <= 1'b0;
      cmd_idx <= '0;
      cmd_dat <= '0;
    end else begin
      go <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (!aw_have && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (!w_have && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (aw_have && w_have && !s_axi_bvalid) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == HR_CTRL || awaddr_q == HR_STAT) ? RESP_OKAY : RESP_SLVERR;
        if (awaddr_q == HR_CTRL && wstrb_q == 4'hF && !busy && wdata_q[CTRL_GO]) begin
          go <= 1'b1;
          cmd_rd <= wdata_q[CTRL_RD];
          cmd_idx <= wdata_q[CTRL_IDX_LSB +: 8];
          cmd_dat <= wdata_q[CTRL_DAT_LSB +: 8];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        s_axi_rdata <= '0;
        if (s_axi_araddr == HR_STAT) begin
          s_axi_rdata <= {16'h0000, rdat, 6'h00, nack, busy};
        end else if (s_axi_araddr != HR_CTRL) begin
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      sda_m <= bus.sda;
      sda_s <= sda_m;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || qtick) begin
      qcnt <= '0;
    end else begin
      qcnt <= qcnt + 8'd1;
    end
  end
  assign qtick = qcnt == 8'(Q_CYC - 1);

  // bytes: 0 address write, 1 index, 2 data or address read, 3 read data
  assign send = !(cmd_rd && bsel == 2'd3); // [RULE18]
  always_comb begin
    unique case (bsel)
      2'd0: txb = {SLAVE_ADDR, 1'b0}; // [RULE15]
      2'd1: txb = cmd_idx;
      2'd2: txb = cmd_rd ? {SLAVE_ADDR, 1'b1} : cmd_dat; // [RULE16] [RULE19]
      default: txb = 8'hFF;
    endcase
  end

  // one clock late, so the device drops its ack on the same edge that the host starts to drive
  always_ff @(posedge clk_sys) begin
    bus.host_sda_o <= 1'b0;
    bus.host_sda_oe <= rst ? 1'b0 : sda_pull;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= H_IDLE;
      q <= '0;
      bitn <= '0;
      bsel <= '0;
      busy <= 1'b0;
      nack <= 1'b0;
      rx <= '0;
      rdat <= '0;
      bus.scl <= 1'b1;
      sda_pull <= 1'b0;
    end else if (st == H_IDLE) begin
      bus.scl <= 1'b1;
      sda_pull <= 1'b0;
      if (go) begin
        st <= H_START;
        busy <= 1'b1;
        nack <= 1'b0;
        bsel <= '0;
        q <= '0;
      end
    end else if (qtick) begin
      q <= q + 2'd1;
      unique case (st)
        H_START: begin
          if (q == 2'd0) begin
            bus.scl <= 1'b0;
            sda_pull <= 1'b0;
          end
          if (q == 2'd1) bus.scl <= 1'b1;
          if (q == 2'd2) sda_pull <= 1'b1;
          if (q == 2'd3) begin
            bus.scl <= 1'b0;
            bitn <= '0;
            st <= H_BIT;
          end
        end
        H_BIT: begin
          if (q == 2'd0) sda_pull <= send && bitn < 4'd8 && !txb[3'(4'd7 - bitn)];
          if (q == 2'd1) bus.scl <= 1'b1;
          if (q == 2'd3) begin
            bus.scl <= 1'b0;
            if (bitn < 4'd8) begin
              bitn <= bitn + 4'd1;
              if (!send) rx <= {rx[6:0], sda_s};
            end else begin
              bitn <= '0;
              if (send && sda_s) begin
                nack <= 1'b1;
                st <= H_STOP;
              end else if ((!cmd_rd && bsel == 2'd2) || bsel == 2'd3) begin
                st <= H_STOP;
              end else if (cmd_rd && bsel == 2'd1) begin
                bsel <= 2'd2;
                st <= H_START; // [RULE16]
              end else begin
                bsel <= bsel + 2'd1;
              end
            end
          end
        end
        H_STOP: begin
          if (q == 2'd0) begin
            bus.scl <= 1'b0;
            sda_pull <= 1'b1;
          end
          if (q == 2'd1) bus.scl <= 1'b1;
          if (q == 2'd2) sda_pull <= 1'b0;
          if (q == 2'd3) begin
            st <= H_IDLE;
            busy <= 1'b0;
            if (cmd_rd && !nack) rdat <= rx;
          end
        end
        default: st <= H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: verification/bl_smbus_properties.sv */
// SMBus link checker
`default_nettype none
module bl_smbus_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // device pull length
  logic [7:0] hold_cnt;
  always_ff @(posedge clk_sys) begin
    if (rst || !dev_sda_oe) begin
      hold_cnt <= 8'h00;
    end else if (hold_cnt != 8'hFF) begin
      hold_cnt <= hold_cnt + 8'h01;
    end
  end
  property p_host_od;
    host_sda_o == 1'b0;
  endproperty
  a_host_od: assert property (p_host_od) else $error("host drives data high");
  property p_dev_od;
    dev_sda_o == 1'b0;
  endproperty
  a_dev_od: assert property (p_dev_od) else $error("device drives data high");
  property p_no_clash;
    !(host_sda_oe && dev_sda_oe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
  property p_dev_edge;
    $changed(dev_sda_oe) |-> !scl;
  endproperty
  a_dev_edge: assert property (p_dev_edge) else $error("device moved data, clock high");
  // ack plus eight zero bits
  property p_dev_hold;
    hold_cnt < 8'd80;
  endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("device held data too long");
  property p_no_dev_start;
    $fell(sda) && scl && $past(scl) |-> host_sda_oe;
  endproperty
  a_no_dev_start: assert property (p_no_dev_start) else $error("start not by host");
  property p_scl_low;
    $fell(scl) |-> ##[1:6] scl;
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock low too long");
  property p_rst_state;
    disable iff (1'b0) rst |=> !dev_sda_oe && !host_sda_oe && scl;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("link not idle in reset");
  c_dev_ack: cover property ($rose(dev_sda_oe));
  c_start: cover property ($fell(sda) && scl);
  c_stop: cover property ($rose(sda) && scl);
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// bench for host and device over SMBus
`default_nettype none
module tb_top
  import bl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RC = 50;
  localparam logic [3:0] T_MFG = 4'h3; // arbitrary value
  localparam logic [2:0] T_REV = 3'h2; // arbitrary value
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic enable_pin = 1'b1, interface_select_pin = 1'b1, analog_select_pin = 1'b1;
  logic pwm_pin = 1'b0, out_ov_threshold = 1'b0, out_over_clamp = 1'b0;
  logic out_below_clamp = 1'b1, ocp_sustained = 1'b0, out_short = 1'b0, over_temp = 1'b0;
  logic [7:0] sink_zero_current = 8'h00, string_sink_pin_ov = 8'h00, sink_on, sink_level;
  logic boost_switch_on, backlight_state_flag, inductor_limit = 1'b0;
  int error_cnt = 0;
  int num_checks = 0;
  logic [31:0] st, d;
  logic [1:0] r;
  logic [35:0] mon_sh;
  logic [7:0] rst_tab [4];
  bl_smbus_if bus ();
  bl_host u_bl_host (.clk_sys, .rst, .bus(bus), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  bl_dev #(.MFG_ID(T_MFG), .REV_ID(T_REV), .RESTART_CYCLES(RC)) u_bl_dev (.clk_sys,
    .rst, .bus(bus), .enable_pin, .interface_select_pin, .analog_select_pin, .pwm_pin,
    .sink_zero_current, .string_sink_pin_ov, .out_ov_threshold, .out_over_clamp,
    .out_below_clamp, .inductor_limit, .ocp_sustained, .out_short, .over_temp,
    .sink_on, .sink_level, .boost_switch_on, .backlight_state_flag);
  bl_smbus_properties u_bl_smbus_properties (.clk_sys, .rst, .scl(bus.scl),
    .sda(bus.sda), .host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe),
    .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe));
  always #(CLK_NS / 2) clk_sys = ~clk_sys;
  // bits since the latest start
  always @(negedge bus.sda) if (bus.scl === 1'b1) mon_sh = 36'h0;
  always @(posedge bus.scl) mon_sh = {mon_sh[34:0], bus.sda};
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task automatic smb(input logic rd, input logic [7:0] i, input logic [7:0] v);
    logic [1:0] rs;
    axw(HR_CTRL, {8'h00, v, i, 6'h00, rd, 1'b1}, rs);
    do axr(HR_STAT, st, rs); while (st[STAT_BUSY] !== 1'b0);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    smb(1'b0, i, v);
    chk({14'h0, st[1:0]}, 16'h0000);
    chk({mon_sh[27:20], mon_sh[18:11]}, {DEF_SLAVE_ADDR, 1'b0, i});
    chk({mon_sh[9:2], 5'h0, mon_sh[19], mon_sh[10], mon_sh[1]}, {v, 8'h00});
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    smb(1'b1, i, 8'h00);
    chk({6'h0, st[1:0], st[15:8]}, {8'h00, e});
    chk({mon_sh[18:11], mon_sh[9:2]}, {DEF_SLAVE_ADDR, 1'b1, e});
    chk({14'h0, mon_sh[10], mon_sh[1]}, 16'h0001);
  endtask
  task automatic boost_seen(input int n, input logic e);
    logic s;
    s = 1'b0;
    repeat (n) begin
      @(posedge clk_sys);
      s = s | boost_switch_on;
    end
    chk({15'h0, s}, {15'h0, e});
  endtask
  task automatic son(input logic [15:0] e);
    chk({sink_on, sink_level}, e);
  endtask
  task automatic opn(input logic [7:0] z);
    out_ov_threshold <= 1'b1;
    sink_zero_current <= z;
    cyc(6);
    out_ov_threshold <= 1'b0;
    sink_zero_current <= 8'h00;
    cyc(6);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    cyc(60000);
    error_cnt++;
    stop_test();
  end
  initial begin
    rst_tab = '{BRT_RST, 8'h00, 8'h00, {1'b1, T_MFG, T_REV}};
    cyc(10);
    rst <= 1'b0;
    cyc(2);
    axr(4'h8, d, r);
    chk({14'h0, r}, {14'h0, RESP_SLVERR});
    axw(4'hC, 32'h0, r);
    chk({14'h0, r}, {14'h0, RESP_SLVERR});
    for (int i = 0; i < 4; i++) rd(i[7:0], rst_tab[i]);
    wr(REG_BRT, 8'h5A);
    rd(REG_BRT, 8'h5A);
    wr(REG_MODE, 8'hFF);
    rd(REG_MODE, 8'h07);
    wr(REG_MODE, 8'h05);
    cyc(6);
    son(16'hFF5A);
    rd(REG_STAT, 8'h08);
    analog_select_pin <= 1'b0;
    pwm_pin <= 1'b1;
    cyc(6);
    son(16'hFFFF);
    pwm_pin <= 1'b0;
    cyc(6);
    son(16'h00FF);
    analog_select_pin <= 1'b1;
    boost_seen(60, 1'b1);
    out_over_clamp <= 1'b1;
    out_below_clamp <= 1'b0;
    cyc(6);
    boost_seen(60, 1'b0);
    out_over_clamp <= 1'b0;
    out_below_clamp <= 1'b1;
    inductor_limit <= 1'b1;
    cyc(6);
    chk({15'h0, boost_switch_on}, 16'h0000);
    inductor_limit <= 1'b0;
    boost_seen(60, 1'b1);
    over_temp <= 1'b1;
    cyc(6);
    chk({sink_on, 6'h0, backlight_state_flag, boost_switch_on}, 16'h0000);
    smb(1'b1, REG_STAT, 8'h00);
    chk({14'h0, st[9:8]}, 16'h0003);
    over_temp <= 1'b0;
    cyc(6);
    son(16'hFF5A);
    out_short <= 1'b1;
    cyc(6);
    out_short <= 1'b0;
    cyc(6);
    son(16'h005A);
    wr(REG_MODE, 8'h05);
    cyc(6);
    son(16'hFF5A);
    string_sink_pin_ov <= 8'h04;
    cyc(6);
    string_sink_pin_ov <= 8'h00;
    cyc(6);
    son(16'hFB5A);
    rd(REG_STAT, 8'h18);
    opn(8'h10);
    son(16'hEB5A);
    rd(REG_STAT, 8'h38);
    wr(REG_MODE, 8'h05);
    cyc(6);
    son(16'hFF5A);
    opn(8'hFF);
    son(16'h005A);
    cyc(RC);
    son(16'hFF5A);
    ocp_sustained <= 1'b1;
    cyc(6);
    ocp_sustained <= 1'b0;
    wr(REG_MODE, 8'h05);
    cyc(6);
    son(16'h005A);
    smb(1'b1, REG_STAT, 8'h00);
    chk({14'h0, st[10], st[8]}, 16'h0003);
    enable_pin <= 1'b0;
    cyc(6);
    enable_pin <= 1'b1;
    cyc(6);
    rd(REG_BRT, BRT_RST);
    rd(REG_STAT, 8'h00);
    smb(1'b0, 8'h04, 8'h11);
    chk({15'h0, st[STAT_NACK]}, 16'h0001);
    smb(1'b1, 8'h07, 8'h00);
    chk({15'h0, st[STAT_NACK]}, 16'h0001);
    rd(REG_BRT, BRT_RST);
    interface_select_pin <= 1'b0;
    cyc(6);
    smb(1'b1, REG_BRT, 8'h00);
    chk({15'h0, st[STAT_NACK]}, 16'h0001);
    stop_test();
  end
endmodule
`default_nettype wire
